// File: ahc_pkg.sv
// Constants shared by the converter host control port.
// Assumes a single 200 MHz clock domain.
package ahc_pkg;
  localparam int CLK_MHZ = 200;
  // Conversion times in nanoseconds; the cycle counts are derived from them.
  localparam int CONV12_NS = 8000;
  localparam int CONV8_NS = 6000;
  localparam int CONV12_CYC = CONV12_NS * CLK_MHZ / 1000;
  localparam int CONV8_CYC = CONV8_NS * CLK_MHZ / 1000;
  localparam int RES_W = 12;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  // Event bits in the interrupt status and mask registers.
  localparam int EV_START = 0;
  localparam int EV_DONE = 1;
  localparam int EV_IGNORED = 2;
  localparam int EV_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ahc_pkg

// File: ahc_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module ahc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : ahc_sync
`default_nettype wire

// File: ahc_port.sv
// Parallel host control port of a 12-bit converter, with an AXI4-Lite view.
// Assumes the pin inputs are asynchronous; the converter core result arrives
// on sample_in and is latched at the end of the conversion.
`timescale 1ns/1ps
`default_nettype none
module ahc_port #(
  parameter int CONV12_CYCLES = ahc_pkg::CONV12_CYC,
  parameter int CONV8_CYCLES = ahc_pkg::CONV8_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host pins
  input wire logic select_n,
  input wire logic chip_enable,
  input wire logic read_convert,
  input wire logic length_or_byte_select,
  input wire logic word_mode,
  output logic [11:0] result_lines_o,
  output logic [11:0] result_lines_oe_n,
  output logic conversion_busy_flag,
  // Converter core sample
  input wire logic [11:0] sample_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);
  localparam int CW = $clog2(CONV12_CYCLES + 1);
  localparam int W = ahc_pkg::RES_W;
  localparam int N = ahc_pkg::NIB_W;
  localparam int B = ahc_pkg::BYTE_W;

  typedef enum logic [1:0] {
    AHC_IDLE = 2'b01,
    AHC_CONV = 2'b10
  } ahc_state_t;

  // Pins pass two flip-flops before use.
  logic [4:0] pins_s;
  ahc_sync #(.W(5)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({select_n, chip_enable, read_convert, length_or_byte_select, word_mode}),
    .q(pins_s)
  );
  wire sel_s = pins_s[4];
  wire ce_s = pins_s[3];
  wire rc_s = pins_s[2];
  wire len_s = pins_s[1];
  wire wmode_s = pins_s[0];

  ahc_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg;
  logic [W-1:0] result_reg;
  logic short_reg;
  logic access_reg;
  logic sw_start_reg;
  logic [ahc_pkg::EV_W-1:0] int_stat_reg, int_mask_reg;

  wire selected = !sel_s && ce_s;
  wire pin_start = selected && !rc_s && !access_reg;
  wire start_req = pin_start || sw_start_reg;
  wire read_act = selected && rc_s;
  wire busy = (state_reg == AHC_CONV);
  wire start_ok = start_req && !busy;
  wire start_ign = start_req && busy;
  wire conv_end = busy && (cnt_reg == '0);

  // Length is sampled once at the start so later changes cannot alter it.
  wire [CW-1:0] load_cnt = len_s ? CW'(CONV8_CYCLES - 1) : CW'(CONV12_CYCLES - 1);

  // An 8-bit conversion leaves the low nibble cleared.
  wire [W-1:0] conv_word = short_reg ? {sample_in[W-1:N], N'(0)} : sample_in;

  // Byte reads use lines 7 to 0 only, so an 8-bit host bus needs no software mask.
  wire [B-1:0] hi_byte = result_reg[W-1:N];
  wire [B-1:0] lo_byte = {result_reg[N-1:0], N'(0)};
  wire [B-1:0] byte_sel = len_s ? lo_byte : hi_byte;
  wire [W-1:0] drive_word = wmode_s ? result_reg : {N'(0), byte_sel};
  wire [W-1:0] drive_oe_n = wmode_s ? '0 : {{N{1'b1}}, {B{1'b0}}};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AHC_IDLE: if (start_ok) state_next = AHC_CONV;
      AHC_CONV: if (conv_end) state_next = AHC_IDLE;
      default: state_next = AHC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= AHC_IDLE;
      cnt_reg <= '0;
      short_reg <= 1'b0;
      result_reg <= '0;
      access_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      access_reg <= selected && !rc_s;
      if (start_ok) begin
        cnt_reg <= load_cnt;
        short_reg <= len_s;
      end else if (busy && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      if (conv_end) result_reg <= conv_word;
    end
  end

  // Pin outputs, all registered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_lines_o <= '0;
      result_lines_oe_n <= '1;
      conversion_busy_flag <= 1'b0;
    end else begin
      conversion_busy_flag <= (state_next == AHC_CONV);
      result_lines_o <= read_act ? drive_word : '0;
      result_lines_oe_n <= read_act ? drive_oe_n : '1;
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  // Ready is registered from the next state, so it behaves as a ready decoded from registers.
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_held_next = !do_write && (aw_held_reg || aw_take);
  wire w_held_next = !do_write && (w_held_reg || w_take);
  wire bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
  wire wr_ctrl = do_write && awaddr_reg == ahc_pkg::ADDR_CTRL && s_axi_wstrb[0];
  wire wr_istat = do_write && awaddr_reg == ahc_pkg::ADDR_INT_STAT && s_axi_wstrb[0];
  wire wr_imask = do_write && awaddr_reg == ahc_pkg::ADDR_INT_MASK && s_axi_wstrb[0];
  wire wr_known = awaddr_reg == ahc_pkg::ADDR_CTRL || awaddr_reg == ahc_pkg::ADDR_STAT ||
                  awaddr_reg == ahc_pkg::ADDR_INT_STAT || awaddr_reg == ahc_pkg::ADDR_INT_MASK ||
                  awaddr_reg == ahc_pkg::ADDR_RESULT;
  wire [ahc_pkg::EV_W-1:0] events = {start_ign, conv_end, start_ok};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bresp <= ahc_pkg::RESP_OKAY;
      sw_start_reg <= 1'b0;
      int_stat_reg <= '0;
      int_mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready <= !w_held_next && !bvalid_next;
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      if (do_write) s_axi_bresp <= wr_known ? ahc_pkg::RESP_OKAY : ahc_pkg::RESP_SLVERR;
      sw_start_reg <= wr_ctrl && wdata_reg[0];
      // Set wins over a write-one clear in the same cycle.
      int_stat_reg <= (int_stat_reg & ~(wr_istat ? wdata_reg[ahc_pkg::EV_W-1:0] : '0)) | events;
      if (wr_imask) int_mask_reg <= wdata_reg[ahc_pkg::EV_W-1:0];
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end
  // AXI4-Lite read path.
  logic [31:0] rd_mux;
  logic rd_known;
  always_comb begin
    rd_mux = '0;
    rd_known = 1'b1;
    case (s_axi_araddr)
      ahc_pkg::ADDR_CTRL: rd_mux = '0;
      ahc_pkg::ADDR_STAT: rd_mux = {30'h0, short_reg, busy};
      ahc_pkg::ADDR_INT_STAT: rd_mux = {29'h0, int_stat_reg};
      ahc_pkg::ADDR_INT_MASK: rd_mux = {29'h0, int_mask_reg};
      ahc_pkg::ADDR_RESULT: rd_mux = {20'h0, result_reg};
      default: rd_known = 1'b0;
    endcase
  end
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= '0;
      s_axi_rresp <= ahc_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_next;
      s_axi_arready <= !rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? ahc_pkg::RESP_OKAY : ahc_pkg::RESP_SLVERR;
      end
    end
  end
endmodule : ahc_port
`default_nettype wire

// File: ahc_port_properties.sv
// Pin checker for the converter host port, bound to its top module.
// Assumes the host holds each pin level for several cycles.
`timescale 1ns/1ps
`default_nettype none
module ahc_port_properties #(
  parameter int C12 = 20,
  parameter int C8 = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  input wire logic select_n,
  input wire logic chip_enable,
  input wire logic read_convert,
  input wire logic length_or_byte_select,
  input wire logic word_mode,
  input wire logic [11:0] result_lines_oe_n,
  input wire logic conversion_busy_flag,
  // Register bus
  input wire logic s_axi_bvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] run_reg;
  logic len_reg;
  wire logic b = conversion_busy_flag;
  wire logic ln = length_or_byte_select;
  wire logic [11:0] z = result_lines_oe_n;
  wire logic rd = !select_n && chip_enable && read_convert;
  wire logic cv = !select_n && chip_enable && !read_convert;
  // Counts busy cycles, so the conversion length is judged at the falling edge.
  always_ff @(posedge aclk) begin
    run_reg <= b ? run_reg + 16'h1 : 16'h0;
    // Length is taken on the first busy cycle, since the host may move the pin later.
    if (b && run_reg == 16'h0) len_reg <= ln;
  end
  a_float_unsel: assert property (select_n [*4] |-> &z) else $error("unselected drive");
  a_float_off: assert property (!chip_enable [*4] |-> &z) else $error("disabled drive");
  a_conv_float: assert property (cv [*4] |-> &z) else $error("convert drive");
  a_word_lanes: assert property ((rd && word_mode) [*4] |-> z == 12'h000) else $error("word");
  a_byte_lanes: assert property ((rd && !word_mode) [*4] |-> z == 12'hF00) else $error("byte");
  a_busy_hold: assert property ($rose(b) |=> b [*8]) else $error("busy short");
  a_busy_len: assert property ($fell(b) |-> run_reg == 16'(len_reg ? C8 : C12)) else $error("len");
  // A software start answers on the bus one cycle before busy rises.
  a_start_cause: assert property ($rose(b) |-> $past(cv, 2) || $past(s_axi_bvalid)) else $error("busy uncaused");
endmodule : ahc_port_properties
bind ahc_port ahc_port_properties #(.C12(CONV12_CYCLES), .C8(CONV8_CYCLES)) i_props (.*);
`default_nettype wire

// File: ahc_host_model.sv
// Host bus controller model driving the converter pins.
// Assumes the bench resolves the data lines onto bus.
`timescale 1ns/1ps
`default_nettype none
module ahc_host_model (
  // Clock
  input wire logic aclk,
  // Pins
  output var logic select_n,
  output var logic chip_enable,
  output var logic read_convert,
  output var logic length_or_byte_select,
  output var logic word_mode,
  // Data lines
  input wire logic [11:0] bus
);
  initial begin
    {select_n, read_convert, word_mode} = 3'b111;
    {chip_enable, length_or_byte_select} = 2'b00;
  end
  // Mode pins settle an edge before selection, so a convert never starts as a brief read.
  task automatic access(input logic rc, input logic ln, input logic wm, input logic [1:0] sel,
      output logic [11:0] data);
    read_convert <= rc;
    length_or_byte_select <= ln;
    word_mode <= wm;
    @(posedge aclk);
    {select_n, chip_enable} <= sel;
    repeat (6) @(posedge aclk);
    data = bus;
    {select_n, chip_enable} <= 2'b10;
    @(posedge aclk);
  endtask : access
endmodule : ahc_host_model
`default_nettype wire

// File: testbench.sv
// Bench for the converter host port: pins through the host model, registers over AXI.
// Assumes one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, select_n, chip_enable, read_convert, length_or_byte_select, word_mode;
  logic conversion_busy_flag, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] result_lines_o, result_lines_oe_n, sample_in, bus, d;
  logic [11:0] last = 12'h000;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic aw, w, ar, dn;
  logic [24:0] rows [2] = '{25'h0A5CA5C, 25'h13F73F0};
  int mismatches, tests_run;
  ahc_port #(.CONV12_CYCLES(20), .CONV8_CYCLES(12)) i_dut (.*);
  ahc_host_model i_host (.*);
  // Released lines toggle each cycle, so a stale value never passes.
  assign bus = (result_lines_oe_n & ~last) | (~result_lines_oe_n & result_lines_o);
  always @(posedge aclk) last <= bus;
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic hang(input logic ok);
    if (!ok) begin
      mismatches++;
      complete_run();
    end
  endtask : hang
  task automatic idle;
    for (int n = 0; n < 60 && conversion_busy_flag !== 1'b0; n++) @(posedge aclk);
    hang(conversion_busy_flag === 1'b0);
  endtask : idle
  // Every channel is judged at the rising edge, on the values that stand there.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    dn = 1'b0;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge aclk);
      {aw, w, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      {v, rs} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
      {s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & !aw, s_axi_wvalid & !w};
      s_axi_arvalid <= s_axi_arvalid & !ar;
      {s_axi_bready, s_axi_rready} <= {s_axi_bready, s_axi_rready} & {2{!dn}};
    end
    hang(dn);
    @(posedge aclk);
  endtask : axi
  initial begin
    {aresetn, sample_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (12) @(posedge aclk);
    chk("reset lanes", 12'hFFF, result_lines_oe_n);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    foreach (rows[i]) begin
      sample_in <= rows[i][23:12];
      i_host.access(1'b0, rows[i][24], 1'b1, 2'b01, d);
      idle();
      i_host.access(1'b1, 1'b0, 1'b1, 2'b01, d);
      chk("word", rows[i][11:0], d);
      i_host.access(1'b1, 1'b0, 1'b0, 2'b01, d);
      chk("high byte", rows[i][11:4], d[7:0]);
      i_host.access(1'b1, 1'b1, 1'b0, 2'b01, d);
      chk("low byte", {rows[i][3:0], 4'h0}, d[7:0]);
      $display("row %0d done", i);
    end
    axi(1'b0, ahc_pkg::ADDR_STAT, 32'h0);
    chk("status", 32'h2, v);
    i_host.access(1'b0, 1'b0, 1'b1, 2'b11, d);
    i_host.access(1'b0, 1'b0, 1'b1, 2'b00, d);
    chk("masked irq", 1'b0, irq);
    chk("no start", 1'b0, conversion_busy_flag);
    axi(1'b1, ahc_pkg::ADDR_INT_MASK, 32'h4);
    i_host.access(1'b0, 1'b0, 1'b1, 2'b01, d);
    i_host.access(1'b0, 1'b0, 1'b1, 2'b01, d);
    idle();
    repeat (3) @(posedge aclk);
    chk("irq set", 1'b1, irq);
    axi(1'b0, ahc_pkg::ADDR_INT_STAT, 32'h0);
    chk("events", 3'h7, v[2:0]);
    axi(1'b1, ahc_pkg::ADDR_INT_STAT, 32'h7);
    repeat (3) @(posedge aclk);
    chk("irq clear", 1'b0, irq);
    axi(1'b1, ahc_pkg::ADDR_CTRL, 32'h1);
    chk("ctrl resp", ahc_pkg::RESP_OKAY, rs);
    chk("sw start", 1'b1, conversion_busy_flag);
    idle();
    axi(1'b0, ahc_pkg::ADDR_RESULT, 32'h0);
    chk("result reg", {20'h0, rows[1][23:12]}, v);
    axi(1'b0, 8'h40, 32'h0);
    chk("unmapped", ahc_pkg::RESP_SLVERR, rs);
    $display("awkward cases done");
    i_host.access(1'b0, 1'b1, 1'b1, 2'b01, d);
    chk("busy before reset", 1'b1, conversion_busy_flag);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("reset busy", 1'b0, conversion_busy_flag);
    chk("reset lanes again", 12'hFFF, result_lines_oe_n);
    chk("reset irq", 1'b0, irq);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi(1'b0, ahc_pkg::ADDR_INT_STAT, 32'h0);
    chk("reset events", 32'h0, v);
    $display("reset case done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
